// ### logic/pic_pkg.sv
// constants, register map and types for the programmable interval clock
package pic_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BASE_RATE_HZ = 1_000_000;
  localparam int unsigned BASE_DIV = CLK_HZ / BASE_RATE_HZ;
  localparam int unsigned DECADE_DIV = 10;
  localparam int unsigned RATE_NUM = 5;
  localparam logic [7:0] BASE_LAST = 8'(BASE_DIV - 1);
  localparam logic [3:0] DECADE_LAST = 4'(DECADE_DIV - 1);

  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] PRESET_OFS = 8'h04;
  localparam logic [7:0] COUNTER_OFS = 8'h08;
  localparam logic [7:0] TRIGSEL_OFS = 8'h0C;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  localparam int EXT_FLAG_BIT = 15;
  localparam int EXT_IE_BIT = 14;
  localparam int MODE_BIT = 8;
  localparam int OVF_FLAG_BIT = 7;
  localparam int OVF_IE_BIT = 6;
  localparam int RATE_LSB = 1;
  localparam int EN_BIT = 0;
  localparam int TRIG_OVF_BIT = 0;
  localparam int TRIG_EXT_BIT = 1;

  localparam logic [2:0] RATE_STOP = 3'h0;
  localparam logic [2:0] RATE_100HZ = 3'h5;
  localparam logic [2:0] RATE_EXT = 3'h6;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  typedef struct packed {
    logic ext_flag;
    logic ext_ie;
    logic mode;
    logic ovf_flag;
    logic ovf_ie;
    logic [2:0] rate;
    logic enable;
  } pic_status_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } pic_req_t;

  typedef enum logic [1:0] {
    PIC_IDLE,
    PIC_WRITE,
    PIC_RD_WAIT,
    PIC_RD_DONE
  } pic_phase_t;

  localparam pic_status_t STATUS_RESET = '0;
  localparam pic_req_t REQ_RESET = '0;
  localparam logic [7:0] PRESET_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [1:0] TRIGSEL_RESET = 2'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage : pic_pkg

// ### logic/pic_rate_div.sv
// crystal divider chain giving the five internal tick rates
module pic_rate_div (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  output logic [pic_pkg::RATE_NUM-1:0] tick_o // 1 MHz .. 100 Hz pulses
);

  logic [7:0] base_q;
  logic [7:0] base_d;

  always_comb begin
    base_d = base_q + 8'h01;
    if (base_q == pic_pkg::BASE_LAST) begin
      base_d = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_q <= 8'h00;
    end else begin
      base_q <= base_d;
    end
  end

  assign tick_o[0] = (base_q == pic_pkg::BASE_LAST);

  // each decade divides the previous tick by ten
  for (genvar i = 1; i < pic_pkg::RATE_NUM; i++) begin : g_decade
    logic [3:0] dec_q;
    logic [3:0] dec_d;

    always_comb begin
      dec_d = dec_q;
      if (tick_o[i-1]) begin
        dec_d = (dec_q == pic_pkg::DECADE_LAST) ? 4'h0 : dec_q + 4'h1;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        dec_q <= 4'h0;
      end else begin
        dec_q <= dec_d;
      end
    end

    assign tick_o[i] = tick_o[i-1] && (dec_q == pic_pkg::DECADE_LAST);
  end

endmodule : pic_rate_div

// ### logic/pic_top.sv
// programmable interval clock with its AHB-Lite register slave
//
// Our own choices: the register offsets and the AHB-Lite register port.
module pic_top (
  input wire logic hclk, // system clock, 200 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always OKAY
  output logic [31:0] hrdata, // read data
  input wire logic external_event_in_n, // external event, active low
  output logic irq_o, // shared interrupt request
  output logic conv_start_o // conversion start pulse
);

  pic_pkg::pic_phase_t phase_q;
  pic_pkg::pic_phase_t phase_d;
  pic_pkg::pic_req_t req_q;
  pic_pkg::pic_req_t req_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic [31:0] rd_mux;

  pic_pkg::pic_status_t st_q;
  pic_pkg::pic_status_t st_d;
  logic [7:0] preset_q;
  logic [7:0] preset_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [1:0] trig_q;
  logic [1:0] trig_d;
  logic conv_q;
  logic conv_d;

  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic prev_q;
  logic prev_d;

  logic [pic_pkg::RATE_NUM-1:0] tick;
  logic [2:0] rate_idx;
  logic rate_tick;
  logic adv;
  logic ovf_evt;
  logic ext_evt;
  logic accept;
  logic wr_en;
  logic wr_stat;
  logic wr_preset;
  logic wr_cnt;
  logic wr_trig;

  pic_rate_div u_rate_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick_o(tick)
  );

  // bus phase tracking: writes take no wait, reads one wait state
  assign accept = hsel && htrans[1] && hready
    && (hsize == pic_pkg::HSIZE_WORD);

  always_comb begin
    phase_d = phase_q;
    req_d = req_q;
    unique case (phase_q)
      pic_pkg::PIC_RD_WAIT: begin
        phase_d = pic_pkg::PIC_RD_DONE;
      end
      pic_pkg::PIC_IDLE, pic_pkg::PIC_WRITE, pic_pkg::PIC_RD_DONE: begin
        if (accept) begin
          req_d.addr = haddr[7:0];
          req_d.write = hwrite;
          phase_d = hwrite ? pic_pkg::PIC_WRITE : pic_pkg::PIC_RD_WAIT;
        end else begin
          phase_d = pic_pkg::PIC_IDLE;
        end
      end
    endcase
  end

  assign wr_en = (phase_q == pic_pkg::PIC_WRITE);
  assign wr_stat = wr_en && (req_q.addr == pic_pkg::STATUS_OFS);
  assign wr_preset = wr_en && (req_q.addr == pic_pkg::PRESET_OFS);
  assign wr_cnt = wr_en && (req_q.addr == pic_pkg::COUNTER_OFS);
  assign wr_trig = wr_en && (req_q.addr == pic_pkg::TRIGSEL_OFS);

  // read view; unused bits zero, status bit 4 reads one
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (req_q.addr)
      pic_pkg::STATUS_OFS: begin
        rd_mux[pic_pkg::EXT_FLAG_BIT] = st_q.ext_flag;
        rd_mux[pic_pkg::EXT_IE_BIT] = st_q.ext_ie;
        rd_mux[pic_pkg::MODE_BIT] = st_q.mode;
        rd_mux[pic_pkg::OVF_FLAG_BIT] = st_q.ovf_flag;
        rd_mux[pic_pkg::OVF_IE_BIT] = st_q.ovf_ie;
        rd_mux[4] = 1'b1;
        rd_mux[pic_pkg::RATE_LSB +: 3] = st_q.rate;
        rd_mux[pic_pkg::EN_BIT] = st_q.enable;
      end
      pic_pkg::PRESET_OFS: begin
        rd_mux[7:0] = preset_q;
      end
      pic_pkg::COUNTER_OFS: begin
        rd_mux[7:0] = cnt_q;
      end
      pic_pkg::TRIGSEL_OFS: begin
        rd_mux[1:0] = trig_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    hrdata_d = hrdata_q;
    if (phase_q == pic_pkg::PIC_RD_WAIT) begin
      hrdata_d = rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= pic_pkg::PIC_IDLE;
      req_q <= pic_pkg::REQ_RESET;
      hrdata_q <= pic_pkg::RDATA_RESET;
    end else begin
      phase_q <= phase_d;
      req_q <= req_d;
      hrdata_q <= hrdata_d;
    end
  end

  assign hreadyout = (phase_q != pic_pkg::PIC_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // external input: two-flop synchroniser, then falling edge
  always_comb begin
    sync_d = {sync_q[0], external_event_in_n};
    prev_d = sync_q[1];
  end

  assign ext_evt = prev_q && !sync_q[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q <= 2'h3;
      prev_q <= 1'b1;
    end else begin
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // time base selection
  assign rate_idx = st_q.rate - 3'h1;

  always_comb begin
    rate_tick = 1'b0;
    if (st_q.rate == pic_pkg::RATE_EXT) begin
      rate_tick = ext_evt && st_q.mode;
    end else if (st_q.rate != pic_pkg::RATE_STOP
                 && st_q.rate <= pic_pkg::RATE_100HZ) begin
      rate_tick = tick[rate_idx];
    end
  end

  assign adv = st_q.enable && rate_tick;
  assign ovf_evt = adv && (cnt_q == pic_pkg::COUNT_MAX);

  // counter, preset and status next state
  always_comb begin
    st_d = st_q;
    preset_d = preset_q;
    cnt_d = cnt_q;
    trig_d = trig_q;
    if (wr_stat) begin
      st_d.ext_flag = hwdata[pic_pkg::EXT_FLAG_BIT];
      st_d.ext_ie = hwdata[pic_pkg::EXT_IE_BIT];
      st_d.mode = hwdata[pic_pkg::MODE_BIT];
      st_d.ovf_flag = hwdata[pic_pkg::OVF_FLAG_BIT];
      st_d.ovf_ie = hwdata[pic_pkg::OVF_IE_BIT];
      st_d.rate = hwdata[pic_pkg::RATE_LSB +: 3];
      st_d.enable = hwdata[pic_pkg::EN_BIT];
    end
    if (adv) begin
      cnt_d = cnt_q + 8'h01;
      if (ovf_evt) begin
        cnt_d = st_q.mode ? preset_q : 8'h00;
      end
    end
    // hardware events win over a software clear in the same cycle
    if (ovf_evt) begin
      st_d.ovf_flag = 1'b1;
      if (!st_q.mode) begin
        st_d.enable = 1'b0;
      end
    end
    if (ext_evt) begin
      st_d.ext_flag = 1'b1;
    end
    if (wr_preset) begin
      preset_d = hwdata[7:0];
      if (!st_q.enable) begin
        cnt_d = hwdata[7:0];
      end
    end
    if (wr_cnt) begin
      cnt_d = hwdata[7:0];
    end
    if (wr_trig) begin
      trig_d = hwdata[1:0];
    end
  end

  always_comb begin
    conv_d = (ovf_evt && trig_q[pic_pkg::TRIG_OVF_BIT])
      || (ext_evt && trig_q[pic_pkg::TRIG_EXT_BIT]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= pic_pkg::STATUS_RESET;
      preset_q <= pic_pkg::PRESET_RESET;
      cnt_q <= pic_pkg::COUNTER_RESET;
      trig_q <= pic_pkg::TRIGSEL_RESET;
      conv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      preset_q <= preset_d;
      cnt_q <= cnt_d;
      trig_q <= trig_d;
      conv_q <= conv_d;
    end
  end

  // one level request; stays up until software clears the flag
  assign irq_o = (st_q.ovf_flag && st_q.ovf_ie)
    || (st_q.ext_flag && st_q.ext_ie);
  assign conv_start_o = conv_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  count_step_a: assert property (
    adv && (cnt_q != pic_pkg::COUNT_MAX) && !wr_en
      |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not step on tick");

  reload_a: assert property (
    ovf_evt && st_q.mode && !wr_en |=> cnt_q == $past(preset_q))
    else $error("repeat mode reload missing");

  preset_load_a: assert property (
    wr_preset && !st_q.enable |=> cnt_q == $past(hwdata[7:0]))
    else $error("preset write did not load stopped counter");

  single_stop_a: assert property (
    ovf_evt && !st_q.mode && !wr_en
      |=> !st_q.enable && st_q.ovf_flag && cnt_q == 8'h00 && !adv)
    else $error("single mode did not stop at overflow");

  ovf_read_a: assert property (
    phase_q == pic_pkg::PIC_RD_WAIT && req_q.addr == pic_pkg::STATUS_OFS
      |=> hreadyout && hrdata[7] == $past(st_q.ovf_flag))
    else $error("overflow flag not seen at bit 7");

  ovf_irq_a: assert property (
    ovf_evt && st_q.ovf_ie && !wr_stat |=> irq_o)
    else $error("overflow did not raise interrupt");

  single_ext_a: assert property (
    !st_q.mode && st_q.rate == pic_pkg::RATE_EXT |-> !adv)
    else $error("single mode counted external events");

  base_rate_a: assert property (
    tick[0] |-> ##1 !tick[0] [*8] ##192 tick[0])
    else $error("1 MHz tick period wrong");

  ext_count_a: assert property (
    ext_evt && st_q.enable && st_q.mode && st_q.rate == pic_pkg::RATE_EXT
      |-> adv)
    else $error("external event not counted");

  ext_flag_a: assert property (
    $fell(sync_q[1]) |-> ext_evt ##1 st_q.ext_flag)
    else $error("falling input did not set external flag");

  ext_pulse_a: assert property (
    ext_evt |=> !ext_evt)
    else $error("external event longer than one cycle");

  conv_pulse_a: assert property (
    ovf_evt && trig_q[pic_pkg::TRIG_OVF_BIT] |=> conv_start_o)
    else $error("overflow did not start conversion");

  irq_hold_a: assert property (
    irq_o && !wr_stat |=> irq_o)
    else $error("interrupt dropped while pending");

endmodule : pic_top

// ### bench/pic_ext_src.sv
// external event source on the active-low event input
module pic_ext_src (
  input wire logic hclk, // system clock
  output logic ev_n // event line, active low
);
  timeunit 1ns;
  timeprecision 100ps;

  initial ev_n = 1'b1; // idle high

  // low 350 ns, high 350 ns: 700 ns period, below 1.5 MHz
  task automatic fall();
    @(posedge hclk);
    ev_n <= 1'b0;
    repeat (70) @(posedge hclk);
  endtask : fall

  task automatic rise();
    @(posedge hclk);
    ev_n <= 1'b1;
    repeat (70) @(posedge hclk);
  endtask : rise
endmodule : pic_ext_src

// ### bench/programmable_interval_clock_tb.sv
// self-checking bench of the programmable interval clock
module programmable_interval_clock_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic irq_o;
  logic conv_start_o;
  logic ev_n;
  logic [31:0] rd;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int conv_cnt = 0;
  int n;
  int c0;

  always #2.5 hclk = ~hclk;

  pic_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .external_event_in_n(ev_n),
    .irq_o(irq_o), .conv_start_o(conv_start_o));

  pic_ext_src i_src (.hclk(hclk), .ev_n(ev_n));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (conv_start_o === 1'b1) conv_cnt <= conv_cnt + 1;
    if (cyc == 80000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // interrupt level compared once settled, off the clock edge
  task automatic irq_chk(input logic e, input string m);
    @(negedge hclk);
    chk({31'h0, irq_o}, {31'h0, e}, m);
  endtask : irq_chk

  // one single word transfer; ready sampled at the rising edge
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    ahb(1'b1, a, wd, rd);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, string m);
    ahb(1'b0, a, 32'h0000_0000, rd);
    chk(rd, e, m);
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask : rchk

  task automatic wait_conv(input int max, output int cnt);
    cnt = 0;
    do begin
      @(negedge hclk);
      cnt++;
    end while (conv_start_o !== 1'b1 && cnt < max);
  endtask : wait_conv

  task automatic t_regs();
    rchk(pic_pkg::STATUS_OFS, 32'h0000_0010, "status reset");
    rchk(pic_pkg::COUNTER_OFS, 32'h0000_0000, "counter reset");
    rchk(8'h10, 32'h0000_0000, "unmapped");
    wr(pic_pkg::PRESET_OFS, 32'h0000_00A5);
    rchk(pic_pkg::PRESET_OFS, 32'h0000_00A5, "preset rw");
    rchk(pic_pkg::COUNTER_OFS, 32'h0000_00A5, "stopped load");
    wr(pic_pkg::COUNTER_OFS, 32'h0000_005A);
    rchk(pic_pkg::COUNTER_OFS, 32'h0000_005A, "counter write");
  endtask : t_regs

  task automatic t_single();
    wr(pic_pkg::PRESET_OFS, 32'h0000_00FE);
    wr(pic_pkg::TRIGSEL_OFS, 32'h0000_0001);
    c0 = conv_cnt;
    wr(pic_pkg::STATUS_OFS, 32'h0000_0043);
    wait_conv(1000, n);
    chk(32'((n > 190) && (n < 420)), 32'h1, "two ticks");
    irq_chk(1'b1, "ovf irq");
    repeat (500) @(posedge hclk);
    chk(32'(conv_cnt - c0), 32'h1, "one trigger");
    rchk(pic_pkg::STATUS_OFS, 32'h0000_00D2, "stopped, flag");
    rchk(pic_pkg::COUNTER_OFS, 32'h0000_0000, "wrapped");
    wr(pic_pkg::STATUS_OFS, 32'h0000_0042);
    irq_chk(1'b0, "irq cleared");
    wr(pic_pkg::PRESET_OFS, 32'h0000_00FF);
    wr(pic_pkg::STATUS_OFS, 32'h0000_0043);
    wait_conv(1000, n);
    chk(32'(n < 206), 32'h1, "re-armed");
    wr(pic_pkg::STATUS_OFS, 32'h0000_0000);
  endtask : t_single

  task automatic t_repeat();
    wr(pic_pkg::PRESET_OFS, 32'h0000_00FC);
    wr(pic_pkg::STATUS_OFS, 32'h0000_0103);
    wait_conv(1000, n);
    wait_conv(1000, n);
    chk(32'(n), 32'd800, "reload period");
    irq_chk(1'b0, "masked");
    rchk(pic_pkg::STATUS_OFS, 32'h0000_0193, "polled flag");
    wr(pic_pkg::STATUS_OFS, 32'h0000_0000);
  endtask : t_repeat

  task automatic t_rates();
    logic [2:0] rt [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    int per [5] = '{1000, 200, 2000, 20000, 1000};
    for (int i = 0; i < 5; i++) begin
      wr(pic_pkg::PRESET_OFS, 32'h0000_00FF);
      wr(pic_pkg::STATUS_OFS, 32'h0000_0101 | {28'h0, rt[i], 1'b0});
      // stopped rates must run the wait out with no pulse
      if (rt[i] == 3'h0 || rt[i] == 3'h7) begin
        wait_conv(per[i], n);
      end else begin
        wait_conv(per[i] + 10, n);
        wait_conv(per[i] + 10, n);
      end
      chk(32'(n), 32'(per[i]), "rate period");
      wr(pic_pkg::STATUS_OFS, 32'h0000_0000);
    end
  endtask : t_rates

  task automatic t_ext();
    wr(pic_pkg::PRESET_OFS, 32'h0000_00FD);
    wr(pic_pkg::TRIGSEL_OFS, 32'h0000_0002);
    rchk(pic_pkg::TRIGSEL_OFS, 32'h0000_0002, "trigger select");
    wr(pic_pkg::STATUS_OFS, 32'h0000_410D);
    c0 = conv_cnt;
    i_src.fall();
    rchk(pic_pkg::STATUS_OFS, 32'h0000_C11D, "ext flag");
    irq_chk(1'b1, "ext irq");
    i_src.rise();
    rchk(pic_pkg::COUNTER_OFS, 32'h0000_00FE, "ext count");
    repeat (2) begin
      i_src.fall();
      i_src.rise();
    end
    rchk(pic_pkg::COUNTER_OFS, 32'h0000_00FD, "ext reload");
    rchk(pic_pkg::STATUS_OFS, 32'h0000_C19D, "both flags");
    chk(32'(conv_cnt - c0), 32'h3, "ext triggers");
    wr(pic_pkg::STATUS_OFS, 32'h0000_000D);
    irq_chk(1'b0, "flags cleared");
    i_src.fall();
    i_src.rise();
    rchk(pic_pkg::COUNTER_OFS, 32'h0000_00FD, "single ext");
    wr(pic_pkg::STATUS_OFS, 32'h0000_0000);
  endtask : t_ext

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_single();
    t_repeat();
    t_rates();
    t_ext();
    print_verdict();
  end
endmodule : programmable_interval_clock_tb
